// File: logic/hub_identity_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module hub_identity_config_regs (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic dynamic_power_on_i,
	input wire logic local_power_present_pin_i,
	input wire logic host_single_translator_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] product_id_high_o,
	output logic [15:0] release_number_o,
	output logic self_powered_o,
	output logic hub_status_local_power_o,
	output logic suspend_indicator_pin_mode_o,
	output logic high_speed_capable_o,
	output logic multi_translator_mode_o,
	output logic single_translator_mode_o
);

	// ***************************************************
	// State
	// ***************************************************
	typedef struct packed {
		logic [7:0] product_id_high_ff;
		logic [7:0] release_low_ff;
		logic [7:0] release_high_ff;
		logic [7:0] cfg_one_ff;
		logic [7:0] rdata_ff;
		logic self_powered_ff;
		logic hub_status_ff;
		logic suspend_mode_ff;
		logic high_speed_ff;
		logic multi_tt_ff;
		logic single_tt_ff;
	} state_type;

	state_type st_ff;
	state_type nxt_st;
	logic res_self;
	logic res_status;
	logic res_suspend;
	logic [7:0] cfg_one_next;

	function automatic logic addr_is(input logic [7:0] addr,
		input logic [7:0] offs);
		addr_is = (addr == offs);
	endfunction

	function automatic logic [7:0] cfg_after_write(input logic [7:0] cur,
		input logic wr, input logic [7:0] addr, input logic [7:0] data);
		if (wr && addr_is(addr, hub_cfg_pkg::OFFS_CONFIG_ONE)) begin
			// Reserved bit never stored
			cfg_after_write = data & hub_cfg_pkg::CONFIG_ONE_MASK;
		end else begin
			cfg_after_write = cur;
		end
	endfunction

	// Kept apart from the state copy so the resolver forms no loop
	assign cfg_one_next = cfg_after_write(st_ff.cfg_one_ff, reg_write_i,
		reg_addr_i, reg_wdata_i);

	// Resolver sees the value being written this cycle
	power_source_resolver resolver (
		.power_source_select_i(cfg_one_next[hub_cfg_pkg::POS_POWER_SOURCE]),
		.dynamic_power_on_i(dynamic_power_on_i),
		.local_power_present_pin_i(local_power_present_pin_i),
		.self_powered_o(res_self),
		.hub_status_local_power_o(res_status),
		.suspend_mode_o(res_suspend)
	);

	// ***************************************************
	// Next state
	// ***************************************************
	always_comb begin
		nxt_st = st_ff;
		if (reg_write_i) begin
			if (addr_is(reg_addr_i, hub_cfg_pkg::OFFS_PRODUCT_ID_HIGH)) begin
				nxt_st.product_id_high_ff = reg_wdata_i;
			end
			if (addr_is(reg_addr_i, hub_cfg_pkg::OFFS_RELEASE_LOW)) begin
				nxt_st.release_low_ff = reg_wdata_i;
			end
			if (addr_is(reg_addr_i, hub_cfg_pkg::OFFS_RELEASE_HIGH)) begin
				nxt_st.release_high_ff = reg_wdata_i;
			end
		end
		nxt_st.cfg_one_ff = cfg_one_next;
		if (reg_read_i) begin
			if (addr_is(reg_addr_i, hub_cfg_pkg::OFFS_PRODUCT_ID_HIGH)) begin
				nxt_st.rdata_ff = st_ff.product_id_high_ff;
			end else if (addr_is(reg_addr_i,
				hub_cfg_pkg::OFFS_RELEASE_LOW)) begin
				nxt_st.rdata_ff = st_ff.release_low_ff;
			end else if (addr_is(reg_addr_i,
				hub_cfg_pkg::OFFS_RELEASE_HIGH)) begin
				nxt_st.rdata_ff = st_ff.release_high_ff;
			end else if (addr_is(reg_addr_i,
				hub_cfg_pkg::OFFS_CONFIG_ONE)) begin
				nxt_st.rdata_ff = st_ff.cfg_one_ff;
			end else begin
				nxt_st.rdata_ff = hub_cfg_pkg::RDATA_UNMAPPED;
			end
		end
		// Config takes effect at once; software must finish before attach
		nxt_st.self_powered_ff = res_self;
		nxt_st.hub_status_ff = res_status;
		nxt_st.suspend_mode_ff = res_suspend;
		nxt_st.high_speed_ff =
			~cfg_one_next[hub_cfg_pkg::POS_HIGH_SPEED_OFF];
		// Host request for one translator overrides the stored choice
		nxt_st.multi_tt_ff = cfg_one_next[hub_cfg_pkg::POS_TRANSLATOR] &
			~host_single_translator_i;
		nxt_st.single_tt_ff = ~nxt_st.multi_tt_ff;
	end

	// ***************************************************
	// Registers
	// ***************************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			st_ff.product_id_high_ff <= hub_cfg_pkg::RST_PRODUCT_ID_HIGH;
			st_ff.release_low_ff <= hub_cfg_pkg::RST_RELEASE_LOW;
			st_ff.release_high_ff <= hub_cfg_pkg::RST_RELEASE_HIGH;
			st_ff.cfg_one_ff <= hub_cfg_pkg::RST_CONFIG_ONE;
			st_ff.rdata_ff <= hub_cfg_pkg::RDATA_UNMAPPED;
			// Matches the reset config: bus powered, high speed, one TT
			st_ff.self_powered_ff <= hub_cfg_pkg::RST_SELF_POWERED;
			st_ff.hub_status_ff <= hub_cfg_pkg::RST_HUB_STATUS;
			st_ff.suspend_mode_ff <= hub_cfg_pkg::RST_SUSPEND_MODE;
			st_ff.high_speed_ff <= hub_cfg_pkg::RST_HIGH_SPEED;
			st_ff.multi_tt_ff <= hub_cfg_pkg::RST_MULTI_TT;
			st_ff.single_tt_ff <= hub_cfg_pkg::RST_SINGLE_TT;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign reg_rdata_o = st_ff.rdata_ff;
	assign product_id_high_o = st_ff.product_id_high_ff;
	assign release_number_o = {st_ff.release_high_ff,
		st_ff.release_low_ff};
	assign self_powered_o = st_ff.self_powered_ff;
	assign hub_status_local_power_o = st_ff.hub_status_ff;
	assign suspend_indicator_pin_mode_o = st_ff.suspend_mode_ff;
	assign high_speed_capable_o = st_ff.high_speed_ff;
	assign multi_translator_mode_o = st_ff.multi_tt_ff;
	assign single_translator_mode_o = st_ff.single_tt_ff;

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	a_pid_write: assert property (
		reg_write_i && reg_addr_i == hub_cfg_pkg::OFFS_PRODUCT_ID_HIGH
		|=> product_id_high_o == $past(reg_wdata_i))
		else $error("product id byte not stored");

	a_release_low: assert property (
		reg_write_i && reg_addr_i == hub_cfg_pkg::OFFS_RELEASE_LOW
		|=> release_number_o[7:0] == $past(reg_wdata_i))
		else $error("release low byte not stored");

	a_release_high: assert property (
		reg_write_i && reg_addr_i == hub_cfg_pkg::OFFS_RELEASE_HIGH
		|=> release_number_o[15:8] == $past(reg_wdata_i))
		else $error("release high byte not stored");

	a_power_static: assert property (
		reg_write_i && reg_addr_i == hub_cfg_pkg::OFFS_CONFIG_ONE &&
		!dynamic_power_on_i
		|=> self_powered_o ==
		$past(reg_wdata_i[hub_cfg_pkg::POS_POWER_SOURCE]))
		else $error("power source bit not applied");

	a_power_dynamic: assert property (
		dynamic_power_on_i
		|=> self_powered_o == $past(local_power_present_pin_i))
		else $error("local power pin not followed");

	a_speed_select: assert property (
		reg_write_i && reg_addr_i == hub_cfg_pkg::OFFS_CONFIG_ONE
		|=> high_speed_capable_o ==
		!$past(reg_wdata_i[hub_cfg_pkg::POS_HIGH_SPEED_OFF]))
		else $error("high speed off bit not applied");

	a_tt_select: assert property (
		reg_write_i && reg_addr_i == hub_cfg_pkg::OFFS_CONFIG_ONE &&
		!host_single_translator_i
		|=> multi_translator_mode_o ==
		$past(reg_wdata_i[hub_cfg_pkg::POS_TRANSLATOR]))
		else $error("translator bit not applied");

	a_host_single: assert property (
		host_single_translator_i
		|=> !multi_translator_mode_o && single_translator_mode_o)
		else $error("host single translator ignored");

	a_status_static: assert property (
		!dynamic_power_on_i
		|=> hub_status_local_power_o ==
		!st_ff.cfg_one_ff[hub_cfg_pkg::POS_POWER_SOURCE] &&
		suspend_indicator_pin_mode_o)
		else $error("status bit or suspend mode wrong");

	a_reserved_zero: assert property (
		reg_read_i && reg_addr_i == hub_cfg_pkg::OFFS_CONFIG_ONE
		|=> reg_rdata_o[6] == 1'b0)
		else $error("reserved bit reads nonzero");

	a_id_readback: assert property (
		reg_read_i && reg_addr_i == hub_cfg_pkg::OFFS_PRODUCT_ID_HIGH
		|=> reg_rdata_o == $past(product_id_high_o))
		else $error("product id byte not read back");

	a_status_dynamic: assert property (
		dynamic_power_on_i
		|=> hub_status_local_power_o == $past(local_power_present_pin_i) &&
		!suspend_indicator_pin_mode_o)
		else $error("status bit not following pin");

	a_translator_pair: assert property (
		multi_translator_mode_o != single_translator_mode_o)
		else $error("translator mode outputs disagree");

endmodule
`default_nettype wire

// File: logic/hub_cfg_pkg.sv
// Operation
// - Read/write byte holding the upper eight bits of the product identifier.
// - Read/write byte holding the low byte of the BCD release number.
// - Read/write high release byte; both release bytes form one 16-bit value.
// - Power-source bit: zero means bus powered, one means self powered.
// - With dynamic power on, the local-power pin decides self or bus power.
// - High-speed-off bit set forces full-speed-only attach, else high/full speed.
// - Translator bit: zero one shared translator, one a translator per port.
// - Host may force single-translator use even when per-port translators are on.
// - Dynamic off: pin is suspend indicator, status bit 0 is inverse power bit.
`default_nettype none
package hub_cfg_pkg;

	// ***************************************************
	// Register offsets
	// ***************************************************
	localparam logic [7:0] OFFS_PRODUCT_ID_HIGH = 8'h03;
	localparam logic [7:0] OFFS_RELEASE_LOW = 8'h04;
	localparam logic [7:0] OFFS_RELEASE_HIGH = 8'h05;
	localparam logic [7:0] OFFS_CONFIG_ONE = 8'h06;

	// ***************************************************
	// Values after reset
	// ***************************************************
	localparam logic [7:0] RST_PRODUCT_ID_HIGH = 8'h00;
	localparam logic [7:0] RST_RELEASE_LOW = 8'h00;
	localparam logic [7:0] RST_RELEASE_HIGH = 8'h00;
	localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// Derived outputs match the reset configuration byte
	localparam logic RST_SELF_POWERED = 1'b0;
	localparam logic RST_HUB_STATUS = 1'b1;
	localparam logic RST_SUSPEND_MODE = 1'b1;
	localparam logic RST_HIGH_SPEED = 1'b1;
	localparam logic RST_MULTI_TT = 1'b0;
	localparam logic RST_SINGLE_TT = 1'b1;

	// ***************************************************
	// Fields of configuration byte one
	// ***************************************************
	localparam int POS_POWER_SOURCE = 7;
	localparam int POS_RESERVED = 6;
	localparam int POS_HIGH_SPEED_OFF = 5;
	localparam int POS_TRANSLATOR = 4;
	// Writable bits; the reserved bit is dropped on write
	localparam logic [7:0] CONFIG_ONE_MASK = 8'hBF;

endpackage
`default_nettype wire

// File: logic/power_source_resolver.sv
`timescale 1ns/10ps
`default_nettype none
module power_source_resolver (
	input wire logic power_source_select_i,
	input wire logic dynamic_power_on_i,
	input wire logic local_power_present_pin_i,
	output logic self_powered_o,
	output logic hub_status_local_power_o,
	output logic suspend_mode_o
);

	// ***************************************************
	// Power source decision
	// ***************************************************
	always_comb begin
		if (dynamic_power_on_i) begin
			// Stored bit is ignored; pin follows the supply
			self_powered_o = local_power_present_pin_i;
			hub_status_local_power_o = local_power_present_pin_i;
			suspend_mode_o = 1'b0;
		end else begin
			self_powered_o = power_source_select_i;
			// Inverted as the hub reports it, odd but intended
			hub_status_local_power_o = ~power_source_select_i;
			suspend_mode_o = 1'b1;
		end
	end

endmodule
`default_nettype wire

// File: tb/upstream_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************
// Upstream host: picks the translator mode
// ***************************************************
module upstream_host_model (
	input wire logic clock_i,
	input wire logic want_single_i,
	output logic host_single_translator_o
);
	// Changes only on an edge, as a host request arrives
	always_ff @(posedge clock_i) begin
		host_single_translator_o <= want_single_i;
	end
endmodule
`default_nettype wire

// File: tb/tb_hub_identity_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
 $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_hub_identity_config_regs;
	// ***************************************************
	// Signals and instances
	// ***************************************************
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr = 1'b0, rd = 1'b0, dyn = 1'b0, lpin = 1'b0, single = 1'b0;
	logic hsel, selfp, stat, susp, hs, multi, single_translator_mode;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pid;
	logic [15:0] rel;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	hub_identity_config_regs dut (.clock_i(clock_i), .srst_i(srst_i),
		.reg_write_i(wr), .reg_read_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .dynamic_power_on_i(dyn),
		.local_power_present_pin_i(lpin), .host_single_translator_i(hsel),
		.reg_rdata_o(rdata), .product_id_high_o(pid),
		.release_number_o(rel), .self_powered_o(selfp),
		.hub_status_local_power_o(stat),
		.suspend_indicator_pin_mode_o(susp), .high_speed_capable_o(hs),
		.multi_translator_mode_o(multi), .single_translator_mode_o(single_translator_mode));
	upstream_host_model host (.clock_i(clock_i), .want_single_i(single),
		.host_single_translator_o(hsel));
	always #50 clock_i = ~clock_i;
	// A hang ends the run through the same report
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			summarize();
		end
	end
	// ***************************************************
	// Helpers
	// ***************************************************
	task summarize;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task step;
		@(posedge clock_i);
		#1;
	endtask
	// Idle cycle after each strobe so it never rises in the same step
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step();
		wr = 1'b0;
		step();
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'b1;
		step();
		rd = 1'b0;
		`CHK(rdata, e)
		step();
	endtask
	task cfg_out(input logic [4:0] e);
		`CHK({selfp, stat, susp, hs, multi}, e)
		`CHK(single_translator_mode, ~e[0])
	endtask
	// ***************************************************
	// Scenarios
	// ***************************************************
	task t_reset;
		`CHK({pid, rel}, 24'h000000)
		cfg_out(5'b01110);
		for (int i = 3; i < 7; i++) rd_reg(8'(i), 8'h00);
	endtask
	task t_ids;
		wr_reg(8'h03, 8'h5A);
		wr_reg(8'h04, 8'h39);
		wr_reg(8'h05, 8'h12);
		`CHK(pid, 8'h5A)
		`CHK(rel, 16'h1239)
		rd_reg(8'h04, 8'h39);
		rd_reg(8'h05, 8'h12);
	endtask
	task t_cfg;
		wr_reg(8'h06, 8'hFF);
		cfg_out(5'b10101);
		rd_reg(8'h06, 8'hBF);
		wr_reg(8'h06, 8'h40);
		rd_reg(8'h06, 8'h00);
		cfg_out(5'b01110);
	endtask
	task t_dyn;
		wr_reg(8'h06, 8'h80);
		dyn = 1'b1;
		step();
		cfg_out(5'b00010);
		lpin = 1'b1;
		step();
		wr_reg(8'h06, 8'h00);
		cfg_out(5'b11010);
		dyn = 1'b0;
		step();
		cfg_out(5'b01110);
	endtask
	task t_host;
		wr_reg(8'h06, 8'h10);
		single = 1'b1;
		step();
		step();
		cfg_out(5'b01110);
		single = 1'b0;
		step();
		step();
		cfg_out(5'b01111);
	endtask
	task t_unmapped;
		wr_reg(8'h07, 8'hFF);
		rd_reg(8'h07, 8'h00);
		rd_reg(8'h06, 8'h10);
		srst_i = 1'b1;
		step();
		srst_i = 1'b0;
		`CHK(pid, 8'h00)
		rd_reg(8'h06, 8'h00);
	endtask
	initial begin
		repeat (10) step();
		srst_i = 1'b0;
		t_reset();
		t_ids();
		t_cfg();
		t_dyn();
		t_host();
		t_unmapped();
		summarize();
	end
endmodule
`default_nettype wire
